// ==== src/agor_regs_top.v ====
// APB register bank for input, gain and offset control of the
// three-channel digitizer front end, with its decoded analog controls.
// Assumes a single 40 MHz clock; analog pads and the PLL hold and clamp
// timing come from elsewhere and arrive here as asynchronous levels.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "agor_regs.vh"

module agor_regs_top (
    // Clock and reset
    input wire REF_CLK,
    input wire NRST,
    // APB slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [31:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [3:0] PSTRB,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // Analog timing levels
    input wire CLAMP_WINDOW,
    input wire PLL_HOLD,
    input wire AUTO_BLACK_LEVEL_EN,
    // Sync inputs
    input wire GREEN_SYNC_INPUT,
    input wire HORIZONTAL_SYNC_INPUT,
    // Input routing and coupling
    output reg SECOND_INPUT_SET,
    output reg POS_TO_CLAMP,
    output reg NEG_TO_CLAMP,
    output reg INPUTS_TO_PADS,
    output reg ANALOG_CLAMP,
    // Colour space handling
    output reg [29:0] CLAMP_LEVEL_MV,
    output reg [2:0] HALF_SCALE_SHIFT,
    output reg [23:0] BLACK_TARGET,
    // Sync selection
    output reg COMPOSITE_SYNC,
    output reg SYNC_OUT,
    // Black level loop
    output reg AUTO_BLACK_LEVEL_RUN,
    // Gain and offset
    output reg [23:0] GAIN_CODE,
    output reg OFFSET_RANGE_QUARTER,
    output reg [29:0] OFFSET_DAC,
    output reg [26:0] DIGITAL_OFFSET,
    output reg OFFSET_DAC_ENABLE
);
    // ------------------------------------------------------------
    // Reset and input synchronisers
    // ------------------------------------------------------------
    reg [1:0] rst_sync;
    wire rst_n;
    // Two stages per asynchronous level; only the second is ever read.
    reg [4:0] in_s1;
    reg [4:0] in_s2;

    // Reset takes hold at once but lets go on a clock edge, so no
    // register sees its release in the middle of a setup window.
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            in_s1 <= 5'h00;
            in_s2 <= 5'h00;
        end else begin
            in_s1 <= {CLAMP_WINDOW, PLL_HOLD, AUTO_BLACK_LEVEL_EN,
                      GREEN_SYNC_INPUT, HORIZONTAL_SYNC_INPUT};
            in_s2 <= in_s1;
        end
    end
    // A level change reaches the decoded outputs on the third edge that
    // samples it: two synchroniser stages and the output register.
    wire clamp_window = in_s2[4];
    wire pll_hold = in_s2[3];
    wire abl_en = in_s2[2];
    wire green_sync = in_s2[1];
    wire horiz_sync = in_s2[0];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [7:0] input_configuration;
    reg [7:0] red_channel_gain;
    reg [7:0] green_channel_gain;
    reg [7:0] blue_channel_gain;
    reg [7:0] red_channel_offset;
    reg [7:0] green_channel_offset;
    reg [7:0] blue_channel_offset;
    reg [7:0] offset_converter_config;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Word index from a byte address; misaligned or high bits miss.
    // Requiring the upper bits to be zero keeps the bank from showing
    // up again at aliases further along the bus.
    function [8:0] agor_index;
        input [31:0] addr;
        begin
            if (addr[1:0] != 2'b00 || addr[31:10] != 22'h0) begin
                agor_index = 9'h1FF;
            end else begin
                agor_index = {1'b0, addr[9:2]};
            end
        end
    endfunction

    wire [8:0] idx = agor_index(PADDR);
    wire access = PSEL && PENABLE && !PREADY;
    wire wr = access && PWRITE && PSTRB[0];
    wire [7:0] wbyte = PWDATA[7:0];
    reg hit;
    reg [7:0] rbyte;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Status word: live routing and active black-level loop.
    // Unmapped indices read as zero and clear hit.
    wire [7:0] status_byte = {2'b00, AUTO_BLACK_LEVEL_RUN, SYNC_OUT,
                              COMPOSITE_SYNC, ANALOG_CLAMP,
                              INPUTS_TO_PADS, SECOND_INPUT_SET};

    always @* begin
        hit = 1'b1;
        rbyte = 8'h00;
        case (idx)
            {1'b0, `AGOR_IDX_INPUT_CFG}: rbyte = input_configuration;
            {1'b0, `AGOR_IDX_RED_GAIN}: rbyte = red_channel_gain;
            {1'b0, `AGOR_IDX_GRN_GAIN}: rbyte = green_channel_gain;
            {1'b0, `AGOR_IDX_BLU_GAIN}: rbyte = blue_channel_gain;
            {1'b0, `AGOR_IDX_RED_OFS}: rbyte = red_channel_offset;
            {1'b0, `AGOR_IDX_GRN_OFS}: rbyte = green_channel_offset;
            {1'b0, `AGOR_IDX_BLU_OFS}: rbyte = blue_channel_offset;
            {1'b0, `AGOR_IDX_OFS_CFG}: rbyte = offset_converter_config;
            {1'b0, `AGOR_IDX_STATUS}: rbyte = status_byte;
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Bus response and register writes
    // ------------------------------------------------------------
    // One wait state: the access phase is answered on its first edge.
    // Reserved bits are masked on write so they always read as zero.
    // A refused access still gets its ready pulse, so the host never
    // waits for an answer that will not come.
    // The status index decodes as a hit but stores nothing on write.
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            input_configuration <= `AGOR_RST_INPUT_CFG;
            red_channel_gain <= `AGOR_RST_GAIN;
            green_channel_gain <= `AGOR_RST_GAIN;
            blue_channel_gain <= `AGOR_RST_GAIN;
            red_channel_offset <= `AGOR_RST_OFS;
            green_channel_offset <= `AGOR_RST_OFS;
            blue_channel_offset <= `AGOR_RST_OFS;
            offset_converter_config <= `AGOR_RST_OFS_CFG;
            PRDATA <= 32'h00000000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= access;
            PSLVERR <= access && !hit;
            PRDATA <= (access && !PWRITE && hit) ? {24'h000000, rbyte}
                                                 : 32'h00000000;
            if (wr && hit) begin
                case (idx)
                    {1'b0, `AGOR_IDX_INPUT_CFG}:
                        input_configuration <=
                            wbyte & `AGOR_MASK_INPUT_CFG;
                    {1'b0, `AGOR_IDX_RED_GAIN}: red_channel_gain <= wbyte;
                    {1'b0, `AGOR_IDX_GRN_GAIN}: green_channel_gain <= wbyte;
                    {1'b0, `AGOR_IDX_BLU_GAIN}: blue_channel_gain <= wbyte;
                    {1'b0, `AGOR_IDX_RED_OFS}: red_channel_offset <= wbyte;
                    {1'b0, `AGOR_IDX_GRN_OFS}: green_channel_offset <= wbyte;
                    {1'b0, `AGOR_IDX_BLU_OFS}: blue_channel_offset <= wbyte;
                    {1'b0, `AGOR_IDX_OFS_CFG}:
                        offset_converter_config <=
                            wbyte & `AGOR_MASK_OFS_CFG;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Offset channels
    // ------------------------------------------------------------
    // All three channels share one synchronised enable, so they change
    // between manual and digital offset on the same edge.
    wire [9:0] dac_r, dac_g, dac_b;
    wire [8:0] dig_r, dig_g, dig_b;
    wire en_r, en_g, en_b;

    agor_offset_chan u_red (
        .code(red_channel_offset),
        .low_bits(offset_converter_config[`AGOR_LSB_RED+1:`AGOR_LSB_RED]),
        .auto_black_level(abl_en),
        .dac_word(dac_r),
        .digital_offset(dig_r),
        .dac_enable(en_r)
    );
    agor_offset_chan u_green (
        .code(green_channel_offset),
        .low_bits(offset_converter_config[`AGOR_LSB_GRN+1:`AGOR_LSB_GRN]),
        .auto_black_level(abl_en),
        .dac_word(dac_g),
        .digital_offset(dig_g),
        .dac_enable(en_g)
    );
    agor_offset_chan u_blue (
        .code(blue_channel_offset),
        .low_bits(offset_converter_config[`AGOR_LSB_BLU+1:`AGOR_LSB_BLU]),
        .auto_black_level(abl_en),
        .dac_word(dac_b),
        .digital_offset(dig_b),
        .dac_enable(en_b)
    );

    // ------------------------------------------------------------
    // Decoded analog controls
    // ------------------------------------------------------------
    wire dc_mode = input_configuration[`AGOR_BIT_DC_COUPLE];
    wire yuv = input_configuration[`AGOR_BIT_COLOUR];
    wire composite_sync_sel = input_configuration[`AGOR_BIT_SYNC_TYPE];
    wire csrc = input_configuration[`AGOR_BIT_COMPOSITE_SYNC_SRC];
    wire hold_clamp = input_configuration[`AGOR_BIT_HOLD_CLAMP];
    // Clamping and the black loop pause in PLL hold unless told not to.
    wire loop_ok = !pll_hold || hold_clamp;

    // Every control is registered once more so each output comes from a
    // flip-flop; it follows a register write by one edge. The reset
    // values describe an AC-coupled RGB front end with manual offset.
    always @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            SECOND_INPUT_SET <= 1'b0;
            POS_TO_CLAMP <= 1'b0;
            NEG_TO_CLAMP <= 1'b1;
            INPUTS_TO_PADS <= 1'b0;
            ANALOG_CLAMP <= 1'b0;
            CLAMP_LEVEL_MV <= {3{`AGOR_CLAMP_LOW_MV}};
            HALF_SCALE_SHIFT <= 3'b111;
            BLACK_TARGET <= {3{`AGOR_TARGET_ZERO}};
            COMPOSITE_SYNC <= 1'b0;
            SYNC_OUT <= 1'b0;
            AUTO_BLACK_LEVEL_RUN <= 1'b0;
            GAIN_CODE <= {3{`AGOR_RST_GAIN}};
            OFFSET_RANGE_QUARTER <= 1'b0;
            OFFSET_DAC <= {3{`AGOR_RST_OFS, 2'b00}};
            DIGITAL_OFFSET <= 27'h0;
            OFFSET_DAC_ENABLE <= 1'b1;
        end else begin
            SECOND_INPUT_SET <=
                input_configuration[`AGOR_BIT_INPUT_SEL];
            // AC mode: positive leg clamps in the window, negative leg
            // is held on the clamp converter and off the pad.
            POS_TO_CLAMP <= !dc_mode && clamp_window && loop_ok;
            NEG_TO_CLAMP <= !dc_mode;
            INPUTS_TO_PADS <= dc_mode;
            ANALOG_CLAMP <= !dc_mode && clamp_window && loop_ok;
            // Order is {red, green, blue}.
            if (yuv) begin
                CLAMP_LEVEL_MV <= {`AGOR_CLAMP_HIGH_MV, `AGOR_CLAMP_LOW_MV,
                                   `AGOR_CLAMP_HIGH_MV};
                HALF_SCALE_SHIFT <= 3'b010;
                BLACK_TARGET <= {`AGOR_TARGET_MID, `AGOR_TARGET_ZERO,
                                 `AGOR_TARGET_MID};
            end else begin
                CLAMP_LEVEL_MV <= {3{`AGOR_CLAMP_LOW_MV}};
                HALF_SCALE_SHIFT <= 3'b111;
                BLACK_TARGET <= {3{`AGOR_TARGET_ZERO}};
            end
            COMPOSITE_SYNC <= composite_sync_sel;
            // Separate sync always passes the horizontal input.
            // The source bit is ignored then, so a stale setting is inert.
            SYNC_OUT <= (composite_sync_sel && !csrc) ? green_sync
                                             : horiz_sync;
            AUTO_BLACK_LEVEL_RUN <= abl_en && loop_ok;
            // Gain = 0.5 + code/170 is realised by the analog stage.
            GAIN_CODE <= {red_channel_gain, green_channel_gain,
                          blue_channel_gain};
            OFFSET_RANGE_QUARTER <=
                offset_converter_config[`AGOR_BIT_OFS_RANGE];
            OFFSET_DAC <= {dac_r, dac_g, dac_b};
            DIGITAL_OFFSET <= {dig_r, dig_g, dig_b};
            OFFSET_DAC_ENABLE <= en_r & en_g & en_b;
        end
    end
endmodule
`default_nettype wire

// ==== include/agor_regs.vh ====
// Constants for the input, gain and offset register bank.
// Assumes a 32-bit APB slave with one register per aligned word.
`ifndef AGOR_REGS_VH
`define AGOR_REGS_VH

// Register indices; the byte address is four times the index.
`define AGOR_IDX_INPUT_CFG 8'h05
`define AGOR_IDX_RED_GAIN 8'h06
`define AGOR_IDX_GRN_GAIN 8'h07
`define AGOR_IDX_BLU_GAIN 8'h08
`define AGOR_IDX_RED_OFS 8'h09
`define AGOR_IDX_GRN_OFS 8'h0A
`define AGOR_IDX_BLU_OFS 8'h0B
`define AGOR_IDX_OFS_CFG 8'h0C
// Own status register: current routing, sync and black-level loop state.
`define AGOR_IDX_STATUS 8'h0D

`define AGOR_RST_INPUT_CFG 8'h00
`define AGOR_RST_GAIN 8'h55
`define AGOR_RST_OFS 8'h80
`define AGOR_RST_OFS_CFG 8'h00

// Input configuration fields.
`define AGOR_BIT_INPUT_SEL 0
`define AGOR_BIT_DC_COUPLE 1
`define AGOR_BIT_COLOUR 2
`define AGOR_BIT_SYNC_TYPE 3
`define AGOR_BIT_COMPOSITE_SYNC_SRC 4
`define AGOR_BIT_HOLD_CLAMP 5
`define AGOR_MASK_INPUT_CFG 8'h3F
// Offset converter fields.
`define AGOR_BIT_OFS_RANGE 0
`define AGOR_MASK_OFS_CFG 8'hFD
`define AGOR_LSB_RED 2
`define AGOR_LSB_GRN 4
`define AGOR_LSB_BLU 6

// Clamp levels in millivolts and fixed codes.
`define AGOR_CLAMP_LOW_MV 10'd300
`define AGOR_CLAMP_HIGH_MV 10'd600
`define AGOR_TARGET_ZERO 8'h00
`define AGOR_TARGET_MID 8'h80
`define AGOR_OFS_MID 8'h80

`endif

// ==== src/agor_offset_chan.v ====
// One channel's offset path: manual 10-bit converter word or signed
// digital offset, depending on the auto black level enable.
// Assumes inputs are stable register outputs on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "agor_regs.vh"

module agor_offset_chan (
    input wire [7:0] code,
    input wire [1:0] low_bits,
    input wire auto_black_level,
    output wire [9:0] dac_word,
    output wire [8:0] digital_offset,
    output wire dac_enable
);
    // Upper eight bits from the offset code, low two from config.
    assign dac_word = {code, low_bits};
    // Code minus midpoint, giving -0x80 .. +0x7F, one count per step.
    assign digital_offset = {1'b0, code}
                            - {1'b0, `AGOR_OFS_MID};
    assign dac_enable = ~auto_black_level;
endmodule
`default_nettype wire

// ==== test/agor_regs_chk.sv ====
// Port-level checker for the input, gain and offset register bank.
// Assumes it is bound into agor_regs_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "agor_regs.vh"
module agor_regs_chk (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    // Levels in
    input wire logic HORIZONTAL_SYNC_INPUT,
    input wire logic AUTO_BLACK_LEVEL_EN,
    // Decoded controls
    input wire logic POS_TO_CLAMP,
    input wire logic NEG_TO_CLAMP,
    input wire logic INPUTS_TO_PADS,
    input wire logic ANALOG_CLAMP,
    input wire logic [29:0] CLAMP_LEVEL_MV,
    input wire logic [2:0] HALF_SCALE_SHIFT,
    input wire logic [23:0] BLACK_TARGET,
    input wire logic COMPOSITE_SYNC,
    input wire logic SYNC_OUT,
    input wire logic AUTO_BLACK_LEVEL_RUN,
    input wire logic OFFSET_DAC_ENABLE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    property p_ready; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
    a_ready: assert property (p_ready)
        else $error("ready missing after access cycle");
    property p_pulse; PREADY |=> !PREADY; endproperty
    a_pulse: assert property (p_pulse)
        else $error("ready held longer than one cycle");
    property p_leg;
        POS_TO_CLAMP |-> NEG_TO_CLAMP && !INPUTS_TO_PADS; endproperty
    a_leg: assert property (p_leg)
        else $error("positive leg clamped outside AC mode");
    property p_dc;
        INPUTS_TO_PADS |-> !NEG_TO_CLAMP && !ANALOG_CLAMP; endproperty
    a_dc: assert property (p_dc)
        else $error("clamp active in DC mode");
    property p_rgb; HALF_SCALE_SHIFT == 3'b111 |->
        CLAMP_LEVEL_MV == {3{10'd300}} && BLACK_TARGET == 24'h0; endproperty
    a_rgb: assert property (p_rgb)
        else $error("wrong clamp or target in RGB mode");
    property p_yuv; HALF_SCALE_SHIFT != 3'b111 |-> HALF_SCALE_SHIFT == 3'b010
        && CLAMP_LEVEL_MV == {10'd600, 10'd300, 10'd600}
        && BLACK_TARGET == 24'h800080; endproperty
    a_yuv: assert property (p_yuv)
        else $error("wrong shift, clamp or target in YUV mode");
    property p_sep;
        (!COMPOSITE_SYNC && HORIZONTAL_SYNC_INPUT) [*6] |-> SYNC_OUT;
    endproperty
    a_sep: assert property (p_sep)
        else $error("separate mode does not pass horizontal sync");
    property p_abl; !AUTO_BLACK_LEVEL_EN [*6] |->
        !AUTO_BLACK_LEVEL_RUN && OFFSET_DAC_ENABLE; endproperty
    a_abl: assert property (p_abl)
        else $error("black loop runs while disabled");
endmodule
bind agor_regs_top agor_regs_chk u_agor_regs_chk (
    .REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .HORIZONTAL_SYNC_INPUT(HORIZONTAL_SYNC_INPUT),
    .AUTO_BLACK_LEVEL_EN(AUTO_BLACK_LEVEL_EN),
    .POS_TO_CLAMP(POS_TO_CLAMP), .NEG_TO_CLAMP(NEG_TO_CLAMP),
    .INPUTS_TO_PADS(INPUTS_TO_PADS), .ANALOG_CLAMP(ANALOG_CLAMP),
    .CLAMP_LEVEL_MV(CLAMP_LEVEL_MV), .HALF_SCALE_SHIFT(HALF_SCALE_SHIFT),
    .BLACK_TARGET(BLACK_TARGET), .COMPOSITE_SYNC(COMPOSITE_SYNC),
    .SYNC_OUT(SYNC_OUT), .AUTO_BLACK_LEVEL_RUN(AUTO_BLACK_LEVEL_RUN),
    .OFFSET_DAC_ENABLE(OFFSET_DAC_ENABLE)
);
`default_nettype wire

// ==== test/agor_apb_host.sv ====
// Host controller model: an APB master for the register bank.
// Assumes one caller at a time; each wait is bounded.
`timescale 1ns/1ps
`default_nettype none
`include "agor_regs.vh"
module agor_apb_host (
    // Clock
    input wire logic REF_CLK,
    // APB
    output logic PSEL,
    output logic PENABLE,
    output logic PWRITE,
    output logic [31:0] PADDR,
    output logic [31:0] PWDATA,
    output logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR
);
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        PSTRB = 4'hF;
    end
    task automatic xfer(input w, input [31:0] a, input [7:0] d,
        output [31:0] rd, output err, output to);
        int n;
        logic [7:0] m;
        m = a == 32'h14 ? `AGOR_MASK_INPUT_CFG : 8'hFF;
        m = a == 32'h30 ? `AGOR_MASK_OFS_CFG : m;
        @(posedge REF_CLK);
        {PSEL, PWRITE, PADDR} <= {1'b1, w, a};
        PWDATA <= {24'h0, d & m};
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        rd = PRDATA;
        err = PSLVERR;
        to = PREADY !== 1'b1;
        {PSEL, PENABLE} <= 2'b0;
        // Released data flips so a stale value cannot look valid.
        PWDATA <= ~PWDATA;
    endtask
    // Lets the bench send writes whose low byte strobe is off.
    task automatic set_strobe(input [3:0] s);
        PSTRB <= s;
    endtask
endmodule
`default_nettype wire

// ==== test/tb_afe_input_gain_offset_regs.sv ====
// Self-checking bench for the input, gain and offset register bank.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "agor_regs.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_afe_input_gain_offset_regs;
    logic REF_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err, to;
    logic [31:0] PADDR, PWDATA, PRDATA, rd, rng;
    logic [3:0] PSTRB;
    logic CLAMP_WINDOW, PLL_HOLD, AUTO_BLACK_LEVEL_EN, ANALOG_CLAMP;
    logic GREEN_SYNC_INPUT, HORIZONTAL_SYNC_INPUT, SECOND_INPUT_SET;
    logic POS_TO_CLAMP, NEG_TO_CLAMP, INPUTS_TO_PADS, COMPOSITE_SYNC;
    logic [29:0] CLAMP_LEVEL_MV, OFFSET_DAC;
    logic [2:0] HALF_SCALE_SHIFT;
    logic [23:0] BLACK_TARGET, GAIN_CODE;
    logic SYNC_OUT, AUTO_BLACK_LEVEL_RUN, OFFSET_RANGE_QUARTER;
    logic OFFSET_DAC_ENABLE;
    logic [26:0] DIGITAL_OFFSET;
    logic [7:0] sh [5:12];
    logic [7:0] v;
    int error_cnt, comparisons, idx;
    agor_regs_top u_agor_regs_top (
        .REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .CLAMP_WINDOW(CLAMP_WINDOW), .PLL_HOLD(PLL_HOLD),
        .AUTO_BLACK_LEVEL_EN(AUTO_BLACK_LEVEL_EN),
        .GREEN_SYNC_INPUT(GREEN_SYNC_INPUT),
        .HORIZONTAL_SYNC_INPUT(HORIZONTAL_SYNC_INPUT),
        .SECOND_INPUT_SET(SECOND_INPUT_SET), .POS_TO_CLAMP(POS_TO_CLAMP),
        .NEG_TO_CLAMP(NEG_TO_CLAMP), .INPUTS_TO_PADS(INPUTS_TO_PADS),
        .ANALOG_CLAMP(ANALOG_CLAMP), .CLAMP_LEVEL_MV(CLAMP_LEVEL_MV),
        .HALF_SCALE_SHIFT(HALF_SCALE_SHIFT), .BLACK_TARGET(BLACK_TARGET),
        .COMPOSITE_SYNC(COMPOSITE_SYNC), .SYNC_OUT(SYNC_OUT),
        .AUTO_BLACK_LEVEL_RUN(AUTO_BLACK_LEVEL_RUN), .GAIN_CODE(GAIN_CODE),
        .OFFSET_RANGE_QUARTER(OFFSET_RANGE_QUARTER),
        .OFFSET_DAC(OFFSET_DAC), .DIGITAL_OFFSET(DIGITAL_OFFSET),
        .OFFSET_DAC_ENABLE(OFFSET_DAC_ENABLE)
    );
    agor_apb_host u_agor_apb_host (
        .REF_CLK(REF_CLK), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR)
    );
    function automatic [31:0] xs(input [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Reserved bits are never stored, so the shadow drops them too.
    function automatic [7:0] wmask(input int i, input [7:0] d);
        if (i == `AGOR_IDX_INPUT_CFG)
            return d & `AGOR_MASK_INPUT_CFG;
        if (i == `AGOR_IDX_OFS_CFG)
            return d & `AGOR_MASK_OFS_CFG;
        return d;
    endfunction
    task automatic conclude;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bus(input w, input [31:0] a, input [7:0] d, input e);
        u_agor_apb_host.xfer(w, a, d, rd, err, to);
        if (to) begin
            error_cnt++;
            conclude();
        end else begin
            `CHK("slverr", e, err)
            if (e)
                `CHK("refused data", 32'h0, rd)
        end
    endtask
    // Expectations come from the shadow copy and the bench's own levels.
    task automatic chk_outs;
        logic [7:0] f, o;
        logic hold, acl, run, syn;
        f = sh[5];
        o = sh[12];
        hold = !PLL_HOLD || f[5];
        acl = !f[1] && CLAMP_WINDOW && hold;
        run = AUTO_BLACK_LEVEL_EN && hold;
        syn = f[3] && !f[4] ? GREEN_SYNC_INPUT : HORIZONTAL_SYNC_INPUT;
        bus(0, `AGOR_IDX_STATUS * 4, 0, 0);
        `CHK("status", {26'h0, run, syn, f[3], acl, f[1], f[0]}, rd)
        `CHK("gain", {sh[6], sh[7], sh[8]}, GAIN_CODE)
        `CHK("dac", {sh[9], o[3:2], sh[10], o[5:4], sh[11], o[7:6]},
            OFFSET_DAC)
        `CHK("digital", {{1'b0, sh[9]} - 9'h080, {1'b0, sh[10]} - 9'h080,
            {1'b0, sh[11]} - 9'h080}, DIGITAL_OFFSET)
        `CHK("range", o[0], OFFSET_RANGE_QUARTER)
        `CHK("route", {f[0], f[1], !f[1], f[3]}, {SECOND_INPUT_SET,
            INPUTS_TO_PADS, NEG_TO_CLAMP,
            COMPOSITE_SYNC})
        `CHK("clamp", {acl, acl},
            {ANALOG_CLAMP, POS_TO_CLAMP})
        `CHK("black", {run, !AUTO_BLACK_LEVEL_EN},
            {AUTO_BLACK_LEVEL_RUN, OFFSET_DAC_ENABLE})
        `CHK("sync", syn, SYNC_OUT)
        `CHK("mv", f[2] ? {10'd600, 10'd300, 10'd600} : {3{10'd300}},
            CLAMP_LEVEL_MV)
        `CHK("target", f[2] ? 24'h800080 : 24'h0,
            BLACK_TARGET)
        `CHK("shift", f[2] ? 3'b010 : 3'b111,
            HALF_SCALE_SHIFT)
    endtask
    initial begin
        REF_CLK = 0;
        forever #12.5 REF_CLK = ~REF_CLK;
    end
    initial begin
        {NRST, CLAMP_WINDOW, PLL_HOLD, AUTO_BLACK_LEVEL_EN} = 4'h0;
        {GREEN_SYNC_INPUT, HORIZONTAL_SYNC_INPUT} = 2'b0;
        {error_cnt, comparisons, rng} = {32'd0, 32'd0, 32'd43};
        repeat (20) @(posedge REF_CLK);
        NRST <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        for (idx = 5; idx <= 12; idx++) begin
            sh[idx] = idx < 9 ? `AGOR_RST_GAIN : `AGOR_RST_OFS;
            sh[idx] = idx == 5 || idx == 12 ? 8'h00 : sh[idx];
            bus(0, idx * 4, 0, 0);
            `CHK("reset", {24'h0, sh[idx]}, rd)
        end
        chk_outs();
        // Unmapped, misaligned and out-of-range places must be refused.
        bus(1, 32'h38, 8'hAA, 1);
        bus(0, 32'h15, 0, 1);
        bus(0, 32'h400, 0, 1);
        // With the low strobe off a write must leave the register alone.
        u_agor_apb_host.set_strobe(4'hE);
        bus(1, `AGOR_IDX_RED_GAIN * 4, 8'h12, 0);
        u_agor_apb_host.set_strobe(4'hF);
        bus(0, `AGOR_IDX_RED_GAIN * 4, 0, 0);
        `CHK("strobe", {24'h0, sh[6]}, rd)
        for (int n = 0; n < 80; n++) begin
            rng = xs(rng);
            {CLAMP_WINDOW, PLL_HOLD, AUTO_BLACK_LEVEL_EN, GREEN_SYNC_INPUT,
                HORIZONTAL_SYNC_INPUT} <= rng[12:8];
            // All-ones and all-zeros codes first, then random traffic.
            idx = 5 + (n < 16 ? n % 8 : rng[18:16]);
            v = n < 8 ? 8'hFF : n < 16 ? 8'h00 : rng[7:0];
            bus(1, idx * 4, v, 0);
            sh[idx] = wmask(idx, v);
            bus(0, idx * 4, 0, 0);
            `CHK("readback", {24'h0, sh[idx]}, rd)
            chk_outs();
        end
        conclude();
    end
endmodule
`default_nettype wire
